// [mac_pkg.sv]
package mac_pkg;
	localparam int data_width  = 32;
	localparam int index_width = 5;
	localparam int reg_count   = 32;
	localparam int mul_cycles  = 2;
	localparam int status_off  = 32'h0000_0000;
	localparam int control_off = 32'h0000_0004;
	localparam int acc_off     = 32'h0000_0008;
	localparam int count_off   = 32'h0000_000c;
	localparam int ctl_accsel_lsb = 0;
	localparam int sts_busy_bit   = 0;
	localparam int sts_done_bit   = 1;
	localparam logic [4:0] acc_index_reset = 5'h00;
	localparam logic [31:0] zero_word     = 32'h0000_0000;
	localparam logic [1:0] htrans_nonseq  = 2'h2;
	localparam logic [2:0] hsize_word     = 3'h2;

	typedef struct packed {
		logic                   start;
		logic                   readra;
		logic                   readrb;
		logic                   writerc;
		logic [index_width-1:0] a;
		logic [index_width-1:0] b;
		logic [index_width-1:0] c;
		logic [data_width-1:0]  dataa;
		logic [data_width-1:0]  datab;
	} op_req_type;

	typedef struct packed {
		logic                  done;
		logic [data_width-1:0] result;
	} op_rsp_type;

	typedef struct packed {
		logic                  valid;
		logic [data_width-1:0] data;
	} conduit_type;
endpackage

// [mac_regfile.sv]
`timescale 1ns/10ps
`default_nettype none
module mac_regfile (
	input  wire logic        hclk,    // system clock
	input  wire logic        clk_en,  // clock qualifier
	input  wire logic        reset,   // sync reset, high
	input  wire logic [4:0]  rd_a,    // read index a
	input  wire logic [4:0]  rd_b,    // read index b
	input  wire logic [4:0]  rd_acc,  // accumulator index
	input  wire logic        wr_en,   // write strobe
	input  wire logic [4:0]  wr_idx,  // write index
	input  wire logic [31:0] wr_data, // write data
	output logic      [31:0] q_a,     // data at a
	output logic      [31:0] q_b,     // data at b
	output logic      [31:0] q_acc    // data at accumulator
);
	logic [31:0] mem [mac_pkg::reg_count];

	// storage for every index
	always_ff @(posedge hclk) begin
		if (reset && clk_en) begin
			for (int i = 0; i < mac_pkg::reg_count; i++) begin
				mem[i] <= mac_pkg::zero_word;
			end
		end else if (clk_en && wr_en) begin
			mem[wr_idx] <= wr_data;
		end
	end

	assign q_a   = mem[rd_a];
	assign q_b   = mem[rd_b];
	assign q_acc = mem[rd_acc];
endmodule
`default_nettype wire

// [mac_mult.sv]
`timescale 1ns/10ps
`default_nettype none
module mac_mult (
	input  wire logic        hclk,   // system clock
	input  wire logic        clk_en, // clock qualifier
	input  wire logic        reset,  // sync reset, high
	input  wire logic [31:0] op_a,   // first factor
	input  wire logic [31:0] op_b,   // second factor
	output logic      [31:0] prod    // registered low product
);
	always_ff @(posedge hclk) begin
		if (reset && clk_en) begin
			prod <= mac_pkg::zero_word;
		end else if (clk_en) begin
			prod <= 32'(op_a * op_b);
		end
	end
endmodule
`default_nettype wire

// [mac_unit.sv]
// Local design decisions: the AHB-Lite register port and the register addresses.
`timescale 1ns/10ps
`default_nettype none
module mac_unit (
	input  wire logic              hclk,       // system clock
	input  wire logic              hresetn,    // bus reset, low
	input  wire logic              clk_en,     // clock qualifier
	input  wire logic              reset,      // system sync reset, high
	input  wire mac_pkg::op_req_type req,      // custom op request
	output mac_pkg::op_rsp_type    rsp,        // done and result
	output mac_pkg::conduit_type   conduit,    // external data path
	input  wire logic              hsel,       // slave select
	input  wire logic [31:0]       haddr,      // address
	input  wire logic [1:0]        htrans,     // transfer type
	input  wire logic              hwrite,     // write
	input  wire logic [2:0]        hsize,      // size
	input  wire logic [31:0]       hwdata,     // write data
	input  wire logic              hready,     // bus ready
	output logic                   hreadyout,  // slave ready
	output logic                   hresp,      // always okay
	output logic [31:0]            hrdata      // read data
);
	typedef enum logic [1:0] {idle, mult, finish} phase_type;

	typedef struct packed {
		phase_type   phase;
		logic [1:0]  wait_cnt;
		logic        done;
		logic [31:0] result;
		logic        cvalid;
		logic [31:0] cdata;
		logic [4:0]  acc_idx;
		logic [31:0] op_count;
		logic        ph_write;
		logic        ph_read;
		logic [3:0]  ph_addr;
		logic [31:0] rdata;
	} state_type;

	state_type state_reg;
	state_type state_next;

	logic [31:0] q_a;
	logic [31:0] q_b;
	logic [31:0] q_acc;
	logic [31:0] prod;
	logic [31:0] op_a;
	logic [31:0] op_b;
	logic [31:0] sum;
	logic        wr_en;
	logic [4:0]  wr_idx;
	logic [31:0] wr_data;
	logic        addr_phase;

	function automatic logic [3:0] word_of(input logic [31:0] addr);
		return addr[5:2];
	endfunction

	assign op_a = req.readra ? req.dataa : q_a;
	assign op_b = req.readrb ? req.datab : q_b;
	// accumulate product
	assign sum  = 32'(q_acc + prod);

	mac_regfile u_regfile (
		.hclk    (hclk),
		.clk_en  (clk_en),
		.reset   (reset),
		.rd_a    (req.a),
		.rd_b    (req.b),
		.rd_acc  (state_reg.acc_idx),
		.wr_en   (wr_en),
		.wr_idx  (wr_idx),
		.wr_data (wr_data),
		.q_a     (q_a),
		.q_b     (q_b),
		.q_acc   (q_acc)
	);

	mac_mult u_mult (
		.hclk   (hclk),
		.clk_en (clk_en),
		.reset  (reset),
		.op_a   (op_a),
		.op_b   (op_b),
		.prod   (prod)
	);

	assign addr_phase = hsel && hready && htrans == mac_pkg::htrans_nonseq;

	always_comb begin
		state_next = state_reg;
		wr_en      = 1'b0;
		wr_idx     = req.c;
		wr_data    = sum;
		state_next.done   = 1'b0;
		state_next.cvalid = 1'b0;
		unique case (state_reg.phase)
			idle: begin
				if (req.start) begin
					state_next.phase    = mult;
					state_next.wait_cnt = 2'(mac_pkg::mul_cycles - 1);
				end
			end
			mult: begin
				if (state_reg.wait_cnt == 2'h0) begin
					state_next.phase = finish;
				end else begin
					state_next.wait_cnt = state_reg.wait_cnt - 2'h1;
				end
			end
			finish: begin
				state_next.phase    = idle;
				state_next.done     = 1'b1;
				state_next.op_count = state_reg.op_count + 32'h1;
				if (req.writerc) begin
					state_next.result = sum;
					wr_en   = 1'b1;
					wr_idx  = state_reg.acc_idx;
					wr_data = mac_pkg::zero_word;
				end else begin
					state_next.result = sum;
					wr_en   = 1'b1;
					wr_idx  = req.c;
					wr_data = sum;
				end
				state_next.cvalid = 1'b1;
				state_next.cdata  = sum;
			end
		endcase

		state_next.ph_write = addr_phase && hwrite;
		state_next.ph_read  = addr_phase && !hwrite;
		state_next.ph_addr  = word_of(haddr);
		if (state_reg.ph_write &&
		    state_reg.ph_addr == word_of(mac_pkg::control_off)) begin
			state_next.acc_idx = hwdata[mac_pkg::ctl_accsel_lsb +: 5];
		end
		state_next.rdata = mac_pkg::zero_word;
		if (addr_phase && !hwrite) begin
			unique case (word_of(haddr))
				word_of(mac_pkg::status_off): begin
					state_next.rdata[mac_pkg::sts_busy_bit] =
						state_reg.phase != idle;
					state_next.rdata[mac_pkg::sts_done_bit] =
						state_reg.done;
				end
				word_of(mac_pkg::control_off):
					state_next.rdata[4:0] = state_reg.acc_idx;
				word_of(mac_pkg::acc_off):
					state_next.rdata = q_acc;
				word_of(mac_pkg::count_off):
					state_next.rdata = state_reg.op_count;
				default:
					state_next.rdata = mac_pkg::zero_word;
			endcase
		end
		if (!clk_en) begin
			state_next.phase    = state_reg.phase;
			state_next.wait_cnt = state_reg.wait_cnt;
			state_next.done     = state_reg.done;
			state_next.result   = state_reg.result;
			state_next.cvalid   = state_reg.cvalid;
			state_next.cdata    = state_reg.cdata;
			state_next.op_count = state_reg.op_count;
			wr_en               = 1'b0;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_reg <= '0;
		end else if (reset && clk_en) begin
			state_reg <= '0;
		end else begin
			state_reg <= state_next;
		end
	end

	assign rsp.done       = state_reg.done;
	assign rsp.result     = state_reg.result;
	assign conduit.valid  = state_reg.cvalid;
	assign conduit.data   = state_reg.cdata;
	assign hreadyout      = 1'b1;
	assign hresp          = 1'b0;
	assign hrdata         = state_reg.rdata;
endmodule
`default_nettype wire

// [mac_unit_chk.sv]
`timescale 1ns/10ps
`default_nettype none
module mac_unit_chk (
	input wire logic                 hclk,      // clock
	input wire logic                 hresetn,   // reset
	input wire logic                 clk_en,    // qualifier
	input wire logic                 reset,     // sync reset
	input wire mac_pkg::op_req_type  req,       // request
	input wire mac_pkg::op_rsp_type  rsp,       // response
	input wire mac_pkg::conduit_type conduit,   // conduit
	input wire logic                 hreadyout, // ready
	input wire logic                 hresp      // response
);
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	a_done_latency: assert property (
		(req.start && clk_en) ##1 clk_en [*3] |-> ##[0:1] rsp.done)
		else $error("done late");
	a_done_single: assert property (
		rsp.done && clk_en |=> !rsp.done) else $error("done too long");
	a_done_cause: assert property (
		rsp.done && $past(clk_en) && $past(clk_en, 2) && $past(clk_en, 3)
		&& $past(clk_en, 4) |-> $past(req.start, 3) || $past(req.start, 4))
		else $error("done without start");
	a_conduit_pair: assert property (
		conduit.valid == rsp.done) else $error("conduit valid apart");
	a_result_sum: assert property (
		rsp.done && req.writerc |-> rsp.result == conduit.data)
		else $error("result not sum");
	a_result_hold: assert property (
		$changed(rsp.result) |-> rsp.done || $past(reset))
		else $error("result moved without done");
	a_hold_noen: assert property (
		!clk_en |=> $stable(rsp) && $stable(conduit))
		else $error("state moved without enable");
	a_reset_idle: assert property (
		reset && clk_en |=> !rsp.done && !conduit.valid)
		else $error("done after reset");
	a_bus_okay: assert property (
		hreadyout && !hresp) else $error("bus not okay");
endmodule
`default_nettype wire

// [mac_core_model.sv]
`timescale 1ns/10ps
`default_nettype none
module mac_core_model (
	input  wire logic                hclk, // clock
	input  wire mac_pkg::op_rsp_type rsp,  // response
	output var mac_pkg::op_req_type  req   // request
);
	initial req = '0;
	task automatic op(input logic ra, rb, wc, input logic [4:0] ia, ib, ic,
		input logic [31:0] da, db, output logic [31:0] res, output logic ok);
		int n;
		@(posedge hclk);
		req <= '{1'b1, ra, rb, wc, ia, ib, ic, da, db};
		@(posedge hclk);
		req.start <= 1'b0;
		n = 0;
		do begin
			@(posedge hclk);
			n++;
		end while (rsp.done !== 1'b1 && n < 30);
		res = wc ? rsp.result : 32'h0;
		ok = rsp.done === 1'b1;
		// released operands stop showing last value
		req.dataa <= ~da;
		req.datab <= ~db;
	endtask
endmodule
`default_nettype wire

// [regfile_custom_op_mac_bench.sv]
`timescale 1ns/10ps
`default_nettype none
module regfile_custom_op_mac_bench;
	logic                 hclk, hresetn, clk_en, reset, hsel, hwrite;
	logic                 hreadyout, hresp;
	logic [1:0]           htrans;
	logic [2:0]           hsize;
	logic [31:0]          haddr, hwdata, hrdata, rd;
	mac_pkg::op_req_type  req;
	mac_pkg::op_rsp_type  rsp;
	mac_pkg::conduit_type conduit;
	int                   miscompares = 0;
	int                   comparisons = 0;
	mac_core_model core_u (.hclk(hclk), .rsp(rsp), .req(req));
	mac_unit dut_u (.hclk(hclk), .hresetn(hresetn), .clk_en(clk_en),
		.reset(reset), .req(req), .rsp(rsp), .conduit(conduit), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
		.hresp(hresp), .hrdata(hrdata));
	task final_report;
		if (miscompares == 0 && comparisons > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task chk(input logic [31:0] seen, exp);
		comparisons++;
		if (seen !== exp) begin
			miscompares++;
			$display("Error at %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task rdy;
		int n;
		n = 0;
		do begin
			@(posedge hclk);
			n++;
		end while (hreadyout !== 1'b1 && n < 20);
		if (hreadyout !== 1'b1) begin
			miscompares++;
			final_report;
		end
	endtask
	task bus(input logic w, input logic [31:0] ad, wd);
		haddr <= ad;
		hwrite <= w;
		htrans <= mac_pkg::htrans_nonseq;
		hsel <= 1'b1;
		hsize <= mac_pkg::hsize_word;
		rdy;
		htrans <= 2'h0;
		hsel <= 1'b0;
		hwdata <= wd;
		rdy;
		rd = hrdata;
	endtask
	task run(input logic ra, rb, wc, input logic [4:0] ia, ib, ic,
		input logic [31:0] da, db, exp);
		logic [31:0] res;
		logic        ok;
		core_u.op(ra, rb, wc, ia, ib, ic, da, db, res, ok);
		if (!ok) begin
			miscompares++;
			final_report;
		end
		chk(wc ? res : conduit.data, exp);
		chk(32'(conduit.valid), 32'h1);
		chk(conduit.data, exp);
	endtask
	task t_accum;
		run(1, 1, 0, 5'h1f, 5'h1e, 5'h00, 32'h3, 32'h5, 32'hf);
		bus(0, mac_pkg::acc_off, 32'h0);
		chk(rd, 32'hf);
		run(1, 1, 0, 5'h1f, 5'h1e, 5'h00, 32'h7, 32'h9, 32'h4e);
		bus(0, mac_pkg::acc_off, 32'h0);
		chk(rd, 32'h4e);
	endtask
	task t_take;
		run(1, 0, 0, 5'h1f, 5'h00, 5'h00, 32'h2, 32'h8, 32'hea);
		run(0, 1, 1, 5'h00, 5'h1f, 5'h1f, 32'h77, 32'h1, 32'h1d4);
		run(1, 0, 1, 5'h00, 5'h1f, 5'h00, 32'h5, 32'h9, 32'h0);
		bus(0, mac_pkg::acc_off, 32'h0);
		chk(rd, 32'h0);
	endtask
	task t_enable;
		fork
			run(1, 1, 1, 5'h3, 5'h4, 5'h5, 32'h6, 32'h7, 32'h2a);
			begin
				repeat (2) @(posedge hclk);
				clk_en <= 1'b0;
				repeat (4) @(posedge hclk);
				clk_en <= 1'b1;
			end
		join
	endtask
	task t_bus;
		bus(1, mac_pkg::control_off, 32'h3);
		bus(0, mac_pkg::control_off, 32'h0);
		chk(rd, 32'h3);
		bus(1, 32'h10, 32'h55);
		bus(0, 32'h10, 32'h0);
		chk(rd, 32'h0);
		bus(0, mac_pkg::count_off, 32'h0);
		chk(rd, 32'h6);
	endtask
	task t_dest;
		run(1, 1, 0, 5'h00, 5'h00, 5'h09, 32'h2, 32'h3, 32'h6);
		bus(0, mac_pkg::acc_off, 32'h0);
		chk(rd, 32'h0);
		run(0, 1, 1, 5'h09, 5'h00, 5'h00, 32'h0, 32'h1, 32'h6);
	endtask
	task t_reset;
		reset <= 1'b1;
		@(posedge hclk);
		reset <= 1'b0;
		bus(0, mac_pkg::count_off, 32'h0);
		chk(rd, 32'h0);
		run(0, 1, 1, 5'h09, 5'h00, 5'h00, 32'h0, 32'h1, 32'h0);
	endtask
	initial begin
		hclk = 1'b0;
		forever #25 hclk = ~hclk;
	end
	initial begin
		hresetn = 1'b0;
		reset = 1'b1;
		clk_en = 1'b1;
		{hsel, hwrite, htrans, hsize, haddr, hwdata} = '0;
		repeat (5) @(posedge hclk);
		hresetn <= 1'b1;
		reset <= 1'b0;
		t_accum;
		t_take;
		t_enable;
		t_bus;
		t_dest;
		t_reset;
		final_report;
	end
endmodule
bind mac_unit mac_unit_chk chk_u (.hclk(hclk), .hresetn(hresetn),
	.clk_en(clk_en), .reset(reset), .req(req), .rsp(rsp),
	.conduit(conduit), .hreadyout(hreadyout), .hresp(hresp));
`default_nettype wire
